// *** logic/mcw_regs.svh ***
// register map, field positions, reset values and timing figures
`ifndef MCW_REGS_SVH
`define MCW_REGS_SVH
// register indices, byte address is four times the index
`define MCW_CTRL0_IDX 8'h02
`define MCW_REV_IDX 8'h7F
`define MCW_CHKEXP_IDX 8'h40
`define MCW_CHKSTS_IDX 8'h41
// reset values and writable bits
`define MCW_CTRL0_RST 32'h0000_0000
`define MCW_CTRL0_MASK 32'hFFFE_0000
`define MCW_CHKEXP_RST 32'h0000_0000
`define MCW_CHKEXP_MASK 32'h0001_FFFF
`define MCW_CHKEN_BIT 16
`define MCW_UPSET_BIT 0
`define MCW_SUMERR_BIT 1
// field positions of the metering control word
`define MCW_RATE_BIT 31
`define MCW_RSV_BIT 30
`define MCW_FREQ_HI 29
`define MCW_FREQ_LO 28
`define MCW_DC_BIT 27
`define MCW_COILB_BIT 26
`define MCW_COILA_BIT 25
`define MCW_SMODE_BIT 24
`define MCW_CHAN_HI 23
`define MCW_CHAN_LO 20
`define MCW_QB_BIT 19
`define MCW_QA_BIT 18
`define MCW_PQHPF_BIT 17
// timing figures in their own units
`define MCW_CLK_NS 10
`define MCW_RMS_MS 10
`define MCW_PWR_MS 20
`define MCW_FRQ1_MS 20
`define MCW_FRQ16_MS 320
`define MCW_FRQ64_MS 1280
`endif

// *** logic/mcw_pkg.sv ***
// shared types of the metering control block
`default_nettype none
package mcw_pkg;
    // line frequency averaging depth codes
    typedef enum logic [1:0] {MCW_FRQ_16, MCW_FRQ_1, MCW_FRQ_64, MCW_FRQ_RSV} mcw_freq_sel_t;
    // fundamental quantity routed to an output channel
    typedef enum logic [2:0] {
        MCW_SRC_PWR_A, MCW_SRC_PWR_B, MCW_SRC_RMS_U, MCW_SRC_RMS_IA, MCW_SRC_RMS_IB
    } mcw_fund_src_t;
endpackage: mcw_pkg
`default_nettype wire

// *** logic/mcw_period_timer.sv ***
// period timer counting base ticks and strobing each period start
`timescale 1ns/1ps
`default_nettype none
module mcw_period_timer #(
    parameter int PW = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // control
    input wire logic sync_clr,
    input wire logic base_tick,
    input wire logic [PW-1:0] period,
    // period start strobe
    output logic pulse
);
    logic [PW-1:0] count_reg;
    logic [PW-1:0] count_next;
    wire last;

    // >= so a shortened period never runs past its new end
    assign last = base_tick && (count_reg >= period - 1'b1);
    assign count_next = (sync_clr || last) ? '0 : base_tick ? count_reg + 1'b1 : count_reg;

    // counter and strobe
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
            pulse <= 1'b0;
        end else begin
            count_reg <= count_next;
            pulse <= last && !sync_clr;
        end
    end

    property p_pulse_cause;
        @(posedge sys_clk) disable iff (!nrst)
        pulse |-> $past(base_tick) && ($past(count_reg) >= $past(period) - 1'b1) && count_reg == '0;
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("period strobe without end");
endmodule: mcw_period_timer
`default_nettype wire

// *** logic/mcw_fund_decode.sv ***
// decoder of the fundamental channel pairing code
`timescale 1ns/1ps
`default_nettype none
module mcw_fund_decode (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // pairing code
    input wire logic [3:0] code,
    // routed quantities
    output var mcw_pkg::mcw_fund_src_t chan1_src,
    output var mcw_pkg::mcw_fund_src_t chan2_src
);
    import mcw_pkg::*;
    mcw_fund_src_t c1_next;
    mcw_fund_src_t c2_next;

    // pairing table, code 0 and unused codes give the power A and power B pair
    always_comb begin
        unique case (code)
            4'h1: begin c1_next = MCW_SRC_PWR_A; c2_next = MCW_SRC_RMS_U; end
            4'h2: begin c1_next = MCW_SRC_PWR_A; c2_next = MCW_SRC_RMS_IA; end
            4'h3: begin c1_next = MCW_SRC_PWR_A; c2_next = MCW_SRC_RMS_IB; end
            4'h4: begin c1_next = MCW_SRC_PWR_B; c2_next = MCW_SRC_RMS_U; end
            4'h5: begin c1_next = MCW_SRC_PWR_B; c2_next = MCW_SRC_RMS_IA; end
            4'h6: begin c1_next = MCW_SRC_PWR_B; c2_next = MCW_SRC_RMS_IB; end
            4'h7: begin c1_next = MCW_SRC_RMS_U; c2_next = MCW_SRC_RMS_IA; end
            4'h8: begin c1_next = MCW_SRC_RMS_U; c2_next = MCW_SRC_RMS_IB; end
            4'h9: begin c1_next = MCW_SRC_RMS_IA; c2_next = MCW_SRC_RMS_IB; end
            default: begin c1_next = MCW_SRC_PWR_A; c2_next = MCW_SRC_PWR_B; end
        endcase
    end

    // registered so the routing outputs come from flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            chan1_src <= MCW_SRC_PWR_A;
            chan2_src <= MCW_SRC_PWR_B;
        end else begin
            chan1_src <= c1_next;
            chan2_src <= c2_next;
        end
    end

    property p_high_codes;
        @(posedge sys_clk) disable iff (!nrst)
        code >= 4'hA |=> chan1_src == MCW_SRC_PWR_A && chan2_src == MCW_SRC_PWR_B;
    endproperty
    a_high_codes: assert property (p_high_codes) else $error("codes 10-15 not as code 0");

    property p_code_nine;
        @(posedge sys_clk) disable iff (!nrst)
        code == 4'h9 |=> chan1_src == MCW_SRC_RMS_IA && chan2_src == MCW_SRC_RMS_IB;
    endproperty
    a_code_nine: assert property (p_code_nine) else $error("code 9 pairing wrong");
endmodule: mcw_fund_decode
`default_nettype wire

// *** logic/mcw_ctrl_top.sv ***
// metering control word zero with revision word, behind an AHB-Lite slave
//
// Function
// - read-only 32-bit revision word at index 0x7F reports hardware version.
// - any of the four reset sources returns control registers to defaults.
// - control registers take part in configuration verification and self-check.
// - bit 31 doubles instant power and RMS refresh periods.
// - bits 29:28 pick 16, 1 or 64 line cycles; code 11 reserved.
// - bit 27 enables direct current metering.
// - bit 26 enables coil sensor processing on current channel B.
// - bit 25 enables coil sensor processing on current channel A.
// - bit 24 derives apparent power from power instead of RMS.
// - bits 23:20 codes 0-9 pick the fundamental channel pair.
// - pairing codes 10-15 behave as code 0.
// - bit 19 makes reactive power B use the fundamental only.
// - bit 18 makes reactive power A use the fundamental only.
// - bit 17 lets total power bypass the high-pass filter.
// - bits 31 to 17 reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "mcw_regs.svh"
module mcw_ctrl_top #(
    parameter logic [31:0] HW_REVISION = 32'h0000_0001, // arbitrary value
    parameter int BASE_TICK_CYCLES = `MCW_RMS_MS * 1000000 / `MCW_CLK_NS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // further reset sources, synchronous
    input wire logic external_reset_pin_n,
    input wire logic rx_line_reset,
    input wire logic global_soft_reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // applied metering controls
    output logic instant_refresh_double,
    output mcw_pkg::mcw_freq_sel_t line_freq_average_sel,
    output logic direct_current_metering_en,
    output logic coil_sensor_en_chan_b,
    output logic coil_sensor_en_chan_a,
    output logic apparent_from_power,
    output mcw_pkg::mcw_fund_src_t fund_chan1_src,
    output mcw_pkg::mcw_fund_src_t fund_chan2_src,
    output logic reactive_b_waveform_sel,
    output logic reactive_a_waveform_sel,
    output logic total_power_filter_bypass,
    // period strobes and self-check
    output logic power_refresh_pulse,
    output logic rms_refresh_pulse,
    output logic line_freq_result_pulse,
    output logic config_check_error
);
    import mcw_pkg::*;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic wr_pend_reg;
    logic [7:0] wr_idx_reg;
    wire access;
    wire [7:0] idx;
    assign access = hsel && htrans[1] && hready && hsize == 3'h2;
    assign idx = haddr[9:2];

    // address phase capture for the write data phase
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
        end else begin
            wr_pend_reg <= access && hwrite;
            wr_idx_reg <= idx;
        end
    end

    // ----------------------------------------------------------------
    // control word and check registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] shadow_inv_reg;
    logic [31:0] chkexp_reg;
    logic [31:0] chkexp_next;
    logic [1:0] chksts_reg;
    logic [1:0] chksts_next;
    wire ctrl_clear;
    wire ctrl_wr;
    wire chkexp_wr;
    wire chksts_wr;
    wire upset;
    wire sum_err;
    wire [15:0] fold;

    // the three synchronous reset sources act alike; clear beats a write landing with it
    assign ctrl_clear = !external_reset_pin_n || rx_line_reset || global_soft_reset;
    assign ctrl_wr = wr_pend_reg && wr_idx_reg == `MCW_CTRL0_IDX;
    assign chkexp_wr = wr_pend_reg && wr_idx_reg == `MCW_CHKEXP_IDX;
    assign chksts_wr = wr_pend_reg && wr_idx_reg == `MCW_CHKSTS_IDX;
    assign ctrl_next = ctrl_clear ? `MCW_CTRL0_RST
        : ctrl_wr ? (hwdata & `MCW_CTRL0_MASK) : ctrl_reg;
    assign chkexp_next = ctrl_clear ? `MCW_CHKEXP_RST
        : chkexp_wr ? (hwdata & `MCW_CHKEXP_MASK) : chkexp_reg;

    // inverted shadow copy catches a flipped bit in the live word
    assign upset = ctrl_reg != ~shadow_inv_reg;
    assign fold = ctrl_reg[31:16] ^ ctrl_reg[15:0];
    assign sum_err = chkexp_reg[`MCW_CHKEN_BIT] && fold != chkexp_reg[15:0];
    // sticky, write one to clear, a new error wins over the clear
    assign chksts_next = (chksts_wr ? chksts_reg & ~hwdata[1:0] : chksts_reg)
        | {sum_err, upset};

    // register storage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `MCW_CTRL0_RST;
            shadow_inv_reg <= ~`MCW_CTRL0_RST;
            chkexp_reg <= `MCW_CHKEXP_RST;
            chksts_reg <= 2'b00;
        end else begin
            ctrl_reg <= ctrl_next;
            shadow_inv_reg <= ~ctrl_next;
            chkexp_reg <= chkexp_next;
            chksts_reg <= chksts_next;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire [31:0] rd_mux;
    // next values so a read right behind a write sees the new data
    assign rd_mux = idx == `MCW_CTRL0_IDX ? ctrl_next
        : idx == `MCW_REV_IDX ? HW_REVISION
        : idx == `MCW_CHKEXP_IDX ? chkexp_next
        : idx == `MCW_CHKSTS_IDX ? {30'h0000_0000, chksts_next}
        : 32'h0000_0000;

    // zero wait state, always OKAY; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= (access && !hwrite) ? rd_mux : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // period timing
    // ----------------------------------------------------------------
    localparam logic [7:0] RMS_T = 8'(`MCW_RMS_MS / `MCW_RMS_MS);
    localparam logic [7:0] PWR_T = 8'(`MCW_PWR_MS / `MCW_RMS_MS);
    localparam logic [7:0] FRQ1_T = 8'(`MCW_FRQ1_MS / `MCW_RMS_MS);
    localparam logic [7:0] FRQ16_T = 8'(`MCW_FRQ16_MS / `MCW_RMS_MS);
    localparam logic [7:0] FRQ64_T = 8'(`MCW_FRQ64_MS / `MCW_RMS_MS);
    logic [31:0] base_cnt_reg;
    logic base_tick_reg;
    logic [31:0] app_reg;
    wire base_last;
    wire [7:0] rms_period;
    wire [7:0] pwr_period;
    wire [7:0] frq_period;

    // base tick of one RMS period at the normal rate
    assign base_last = base_cnt_reg >= 32'(BASE_TICK_CYCLES - 1);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            base_cnt_reg <= 32'h0000_0000;
            base_tick_reg <= 1'b0;
        end else begin
            base_cnt_reg <= (base_last || ctrl_clear) ? 32'h0000_0000 : base_cnt_reg + 32'h1;
            base_tick_reg <= base_last && !ctrl_clear;
        end
    end

    // doubling applies to both instantaneous periods
    assign rms_period = app_reg[`MCW_RATE_BIT] ? RMS_T << 1 : RMS_T;
    assign pwr_period = app_reg[`MCW_RATE_BIT] ? PWR_T << 1 : PWR_T;
    // reserved code runs the default 16-cycle average
    // only code 01 is the single-cycle depth; 11 must not fall into it
    assign frq_period = app_reg[`MCW_FREQ_HI:`MCW_FREQ_LO] == 2'b01 ? FRQ1_T
        : app_reg[`MCW_FREQ_HI:`MCW_FREQ_LO] == 2'b10 ? FRQ64_T : FRQ16_T;

    mcw_period_timer #(.PW(8)) u_rms_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sync_clr(ctrl_clear),
        .base_tick(base_tick_reg),
        .period(rms_period),
        .pulse(rms_refresh_pulse)
    );

    mcw_period_timer #(.PW(8)) u_pwr_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sync_clr(ctrl_clear),
        .base_tick(base_tick_reg),
        .period(pwr_period),
        .pulse(power_refresh_pulse)
    );

    mcw_period_timer #(.PW(8)) u_frq_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sync_clr(ctrl_clear),
        .base_tick(base_tick_reg),
        .period(frq_period),
        .pulse(line_freq_result_pulse)
    );

    // ----------------------------------------------------------------
    // applied word
    // ----------------------------------------------------------------
    wire [31:0] app_next;
    // fields switch at an RMS period start, the averaging depth at the
    // end of its own average so no result mixes two settings
    assign app_next = ctrl_clear ? `MCW_CTRL0_RST
        : {rms_refresh_pulse ? ctrl_reg[31:30] : app_reg[31:30],
           line_freq_result_pulse ? ctrl_reg[29:28] : app_reg[29:28],
           rms_refresh_pulse ? ctrl_reg[27:0] : app_reg[27:0]};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            app_reg <= `MCW_CTRL0_RST;
        end else begin
            app_reg <= app_next;
        end
    end

    mcw_fund_decode u_fund_decode (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .code(app_reg[`MCW_CHAN_HI:`MCW_CHAN_LO]),
        .chan1_src(fund_chan1_src),
        .chan2_src(fund_chan2_src)
    );

    // ----------------------------------------------------------------
    // control outputs
    // ----------------------------------------------------------------
    // bit 30 is stored but steers nothing; software keeps it at zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            instant_refresh_double <= 1'b0;
            line_freq_average_sel <= MCW_FRQ_16;
            direct_current_metering_en <= 1'b0;
            coil_sensor_en_chan_b <= 1'b0;
            coil_sensor_en_chan_a <= 1'b0;
            apparent_from_power <= 1'b0;
            reactive_b_waveform_sel <= 1'b0;
            reactive_a_waveform_sel <= 1'b0;
            total_power_filter_bypass <= 1'b0;
            config_check_error <= 1'b0;
        end else begin
            instant_refresh_double <= app_reg[`MCW_RATE_BIT];
            line_freq_average_sel <= mcw_freq_sel_t'(app_reg[`MCW_FREQ_HI:`MCW_FREQ_LO]);
            direct_current_metering_en <= app_reg[`MCW_DC_BIT];
            coil_sensor_en_chan_b <= app_reg[`MCW_COILB_BIT];
            coil_sensor_en_chan_a <= app_reg[`MCW_COILA_BIT];
            apparent_from_power <= app_reg[`MCW_SMODE_BIT];
            reactive_b_waveform_sel <= app_reg[`MCW_QB_BIT];
            reactive_a_waveform_sel <= app_reg[`MCW_QA_BIT];
            total_power_filter_bypass <= app_reg[`MCW_PQHPF_BIT];
            config_check_error <= |chksts_next;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_ctrl_write;
        access && hwrite && idx == `MCW_CTRL0_IDX ##1 !ctrl_clear;
    endsequence

    sequence s_rev_read;
        access && !hwrite && idx == `MCW_REV_IDX;
    endsequence

    property p_clear_default;
        ctrl_clear |=> ctrl_reg == 32'h0000_0000 && app_reg == 32'h0000_0000;
    endproperty
    a_clear_default: assert property (p_clear_default) else $error("reset source left state");

    property p_rev_read;
        s_rev_read |=> hrdata == HW_REVISION;
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision read wrong");

    property p_ctrl_write;
        s_ctrl_write |=> ctrl_reg == ($past(hwdata) & 32'hFFFE_0000);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_apply_boundary;
        app_reg[27:17] != $past(app_reg[27:17]) |-> $past(rms_refresh_pulse || ctrl_clear);
    endproperty
    a_apply_boundary: assert property (p_apply_boundary) else $error("field applied mid-period");

    property p_upset_flag;
        upset |=> chksts_reg[0] ##1 config_check_error;
    endproperty
    a_upset_flag: assert property (p_upset_flag) else $error("upset not flagged");

    property p_dc_follow;
        rms_refresh_pulse && !ctrl_clear ##1 1'b1 |=> direct_current_metering_en == $past(ctrl_reg[27], 2);
    endproperty
    a_dc_follow: assert property (p_dc_follow) else $error("dc enable not applied");

    property p_rate_follow;
        instant_refresh_double |-> $past(app_reg[31]) && $past(rms_period) == 8'h02;
    endproperty
    a_rate_follow: assert property (p_rate_follow) else $error("refresh doubling wrong");

    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
endmodule: mcw_ctrl_top
`default_nettype wire

// *** tb/mcw_host_model.sv ***
// bus master model standing in for host software on the register bus
`timescale 1ns/1ps
`default_nettype none
`include "mcw_regs.svh"
module mcw_host_model (
    // clock
    input wire logic sys_clk,
    // AHB-Lite master side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // one single word transfer; the caller sits just after a rising edge
    task xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d,
              output logic [31:0] q);
        logic [31:0] wd;
        // software never sets the reserved control bit
        wd = (idx == `MCW_CTRL0_IDX) ? (d & ~32'h4000_0000) : d;
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        do
            @(posedge sys_clk);
        while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wr ? wd : ~hwdata;
        do
            @(posedge sys_clk);
        while (hready !== 1'b1);
        q = hrdata;
        // released lines show no stale value
        hwdata <= ~wd;
        haddr <= ~haddr;
    endtask: xfer
endmodule: mcw_host_model
`default_nettype wire

// *** tb/test_metering_control_word_zero.sv ***
// register and applied-control tests of the metering control block
`timescale 1ns/1ps
`default_nettype none
`include "mcw_regs.svh"
module test_metering_control_word_zero;
    import mcw_pkg::*;
    localparam logic [31:0] REV = 32'h0000_00A5; // arbitrary value
    localparam logic [31:0] V = 32'h8F0E_0000;
    logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp;
    logic [2:0] rs, hsize;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic rd2, dc, cb, ca, ap, qb, qa, hb, pp, rp, lp, cerr;
    mcw_freq_sel_t lf;
    mcw_fund_src_t f1, f2;
    int n_errors = 0;
    int n_checks = 0;
    int n;
    int f1t[10] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 3};
    int f2t[10] = '{1, 2, 3, 4, 2, 3, 4, 3, 4, 4};
    int lfc[4] = '{1, 2, 3, 0};
    int lfp[4] = '{20, 1280, 320, 320};
    wire [2:0] pul = {lp, pp, rp};
    wire [7:0] flags = {rd2, dc, cb, ca, ap, qb, qa, hb};

    mcw_ctrl_top #(.HW_REVISION(REV), .BASE_TICK_CYCLES(10)) dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .external_reset_pin_n(~rs[0]),
        .rx_line_reset(rs[1]), .global_soft_reset(rs[2]), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .instant_refresh_double(rd2), .line_freq_average_sel(lf),
        .direct_current_metering_en(dc), .coil_sensor_en_chan_b(cb),
        .coil_sensor_en_chan_a(ca), .apparent_from_power(ap), .fund_chan1_src(f1),
        .fund_chan2_src(f2), .reactive_b_waveform_sel(qb), .reactive_a_waveform_sel(qa),
        .total_power_filter_bypass(hb), .power_refresh_pulse(pp), .rms_refresh_pulse(rp),
        .line_freq_result_pulse(lp), .config_check_error(cerr));

    mcw_host_model host_u (
        .sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask: chk
    task cyc;
        @(posedge sys_clk);
        #1;
    endtask: cyc
    task wr(input logic [7:0] i, input logic [31:0] d);
        host_u.xfer(1'b1, i, d, q);
        #1;
    endtask: wr
    task rd(input logic [7:0] i);
        host_u.xfer(1'b0, i, 32'h0, q);
        #1;
    endtask: rd
    // bounded wait for a period strobe, k counts the cycles waited
    task wp(input int s, output int k);
        k = 0;
        do begin
            cyc;
            k++;
        end while (pul[s] !== 1'b1 && k < 3000);
        // a strobe that never came is a mismatch, not a silent pass
        if (pul[s] !== 1'b1) begin
            n_errors++;
            $display("[ERR] strobe %0d expected 1 seen %b", s, pul[s]);
        end
    endtask: wp
    task results;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask: results

    // watchdog, the tests need well under this span
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        results;
    end

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        rs = 3'b000;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(`MCW_CTRL0_IDX);
        chk("ctrl reset", 32'h0, q); // default word
        chk("applied reset", 32'h0, {24'h0, flags}); // defaults applied
        chk("chan2 reset", 32'h1, {29'h0, f2}); // pairing code zero
        rd(`MCW_REV_IDX);
        chk("revision", REV, q); // version word
        wr(`MCW_REV_IDX, ~REV);
        rd(`MCW_REV_IDX);
        chk("revision ro", REV, q); // write ignored
        rd(8'h80);
        chk("unmapped", 32'h0, q);
        chk("hresp", 32'h0, {31'h0, hresp});
        $display("test reset_and_revision done");
        // every single-bit field set then cleared, with refresh periods
        for (int j = 0; j < 2; j++) begin
            wp(0, n);
            wr(`MCW_CTRL0_IDX, j ? 32'h0 : (V | 32'h4001_FFFF));
            chk("deferred", j ? 32'hFF : 32'h0, {24'h0, flags}); // old value holds
            rd(`MCW_CTRL0_IDX);
            chk("ctrl readback", j ? 32'h0 : V, q); // stored bits
            wp(0, n);
            // applied word moves one edge after the strobe, outputs one more
            cyc;
            cyc;
            chk("applied", j ? 32'h0 : 32'hFF, {24'h0, flags});
            wp(0, n);
            wp(0, n);
            chk("rms period", j ? 32'd10 : 32'd20, 32'(n)); // one or two base ticks
            wp(1, n);
            wp(1, n);
            chk("power period", j ? 32'd20 : 32'd40, 32'(n)); // power refresh
        end
        $display("test fields_and_refresh done");
        // line frequency depth codes
        for (int j = 0; j < 4; j++) begin
            wr(`MCW_CTRL0_IDX, lfc[j] << 28);
            wp(2, n);
            cyc;
            cyc;
            chk("freq sel", 32'(lfc[j]), {30'h0, lf}); // applied code
            wp(2, n);
            wp(2, n);
            chk("freq period", 32'(lfp[j]), 32'(n)); // averaging depth
        end
        $display("test line_freq done");
        // fundamental pairing table, spare codes included
        for (int c = 0; c < 16; c++) begin
            wp(0, n);
            wr(`MCW_CTRL0_IDX, c << 20);
            wp(0, n);
            cyc;
            cyc;
            chk("chan1", c < 10 ? f1t[c] : 0, {29'h0, f1}); // channel one
            chk("chan2", c < 10 ? f2t[c] : 1, {29'h0, f2}); // channel two
        end
        $display("test pairing done");
        // each synchronous reset source clears the word
        for (int i = 0; i < 3; i++) begin
            wr(`MCW_CTRL0_IDX, V);
            wp(0, n);
            @(posedge sys_clk);
            rs <= 3'b001 << i;
            @(posedge sys_clk);
            rs <= 3'b000;
            rd(`MCW_CTRL0_IDX);
            chk("src ctrl", 32'h0, q); // cleared word
            chk("src applied", 32'h0, {24'h0, flags}); // cleared outputs
        end
        $display("test reset_sources done");
        // self-check of stored settings
        wr(`MCW_CHKEXP_IDX, 32'h0001_0000);
        cyc;
        cyc;
        chk("check quiet", 32'h0, {31'h0, cerr}); // matching sum
        wr(`MCW_CTRL0_IDX, 32'h0800_0000);
        n = 0;
        while (cerr !== 1'b1 && n < 50) begin
            cyc;
            n++;
        end
        chk("check flags", 32'h1, {31'h0, cerr}); // mismatch seen
        wr(`MCW_CTRL0_IDX, 32'h0);
        wr(`MCW_CHKSTS_IDX, 32'h3);
        cyc;
        cyc;
        chk("check cleared", 32'h0, {31'h0, cerr}); // status cleared
        $display("test self_check done");
        results;
    end
endmodule: test_metering_control_word_zero
`default_nettype wire
